// ### hdl/bis_ignition_control_first.sv
`timescale 1ns/1ps
`include "bis_consts.svh"
// Functional notes
// - three trials, then lockout
// - lockout keeps valve and spark off 5 min
// - lockout expiry restarts with three trials
// - only power-on reset ends lockout early
// - flame loss restarts ignition, counts trials
// - power loss drops valve at once
// - power return with demand restarts sequence
// - purge delay before any ignition output
// - outputs need purge done and prove closed
// - spark off on flame detection
// - inducer runs throughout demand
// - inducer follows demand directly
// - rollout open closes valve at once
// - first variant flash codes
// - second variant flash codes
// - valve energized with spark
// - valve held while flame sensed
module bis_ignition_control_first
  import bis_pkg::*;
#(
  // 64-bit counts: the lockout period in clocks does not fit in 32 bits
  parameter longint unsigned PURGE_CYC   = 64'(`BIS_PURGE_S) * 64'(`BIS_CLK_HZ),
  parameter longint unsigned LOCKOUT_CYC = 64'(`BIS_LOCKOUT_S) * 64'(`BIS_CLK_HZ),
  parameter longint unsigned TRIAL_CYC   = 64'(`BIS_TRIAL_S) * 64'(`BIS_CLK_HZ),
  parameter longint unsigned FLASH_CYC   = 64'(`BIS_FLASH_DIV),
  parameter bit              VARIANT_B   = 1'b0
) (
  // clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // link
  bis_link_if.ignition link,
  // status
  input  wire logic hw_fault,
  output logic      led_reg
);
  localparam int CW = 34;
  bis_state_t      state_reg;
  bis_lock_t       lock_cause_reg;
  logic [CW-1:0]   timer_reg;
  logic [1:0]      trials_reg;
  logic            had_flame_reg;
  logic            gas_reg;
  logic            spark_reg;
  logic            sense_reg;
  logic            lockout_reg;
  logic            live;
  logic [CW-1:0]   lim;

  // power and rollout are qualifiers applied in the same cycle
  assign live = link.power_ok & link.rollout_ok;

  always_comb begin
    case (state_reg)
      BIS_PURGE:   lim = CW'(PURGE_CYC);
      BIS_TRIAL:   lim = CW'(TRIAL_CYC);
      BIS_LOCKOUT: lim = CW'(LOCKOUT_CYC);
      default:     lim = '0;
    endcase
  end

  // sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg      <= BIS_IDLE;
      timer_reg      <= '0;
      trials_reg     <= 2'h0;
      had_flame_reg  <= 1'b0;
      lock_cause_reg <= BIS_LOCK_NONE;
    end else begin
      timer_reg <= timer_reg + CW'(1);
      case (state_reg)
        BIS_IDLE: begin
          trials_reg    <= 2'h0;
          had_flame_reg <= 1'b0;
          timer_reg     <= '0;
          if (link.demand && link.power_ok) begin
            state_reg <= BIS_PURGE;
          end
        end
        BIS_PURGE: begin
          if (!link.demand || !link.power_ok) begin
            state_reg <= BIS_IDLE;
          end else if (timer_reg >= lim - CW'(1)) begin
            state_reg <= BIS_WAIT_PROVE;
          end
        end
        BIS_WAIT_PROVE: begin
          timer_reg <= '0;
          if (!link.demand || !link.power_ok) begin
            state_reg <= BIS_IDLE;
          end else if (link.prove_closed && link.rollout_ok) begin
            state_reg  <= BIS_TRIAL;
            trials_reg <= trials_reg + 2'h1;
          end
        end
        BIS_TRIAL: begin
          if (!link.demand || !live) begin
            state_reg <= BIS_IDLE;
          end else if (link.flame_sensed) begin
            state_reg <= BIS_RUN;
          end else if (timer_reg >= lim - CW'(1)) begin
            timer_reg <= '0;
            if (trials_reg >= 2'(`BIS_MAX_TRIALS)) begin
              state_reg      <= BIS_LOCKOUT;
              lock_cause_reg <= had_flame_reg ? BIS_LOCK_LOSSES : BIS_LOCK_TRIALS;
            end else begin
              state_reg <= BIS_WAIT_PROVE;
            end
          end
        end
        BIS_RUN: begin
          had_flame_reg <= 1'b1;
          timer_reg     <= '0;
          if (!link.demand || !live) begin
            state_reg <= BIS_IDLE;
          end else if (!link.flame_sensed) begin
            // flame loss restarts at once, the trial count carries on
            if (trials_reg >= 2'(`BIS_MAX_TRIALS)) begin
              state_reg      <= BIS_LOCKOUT;
              lock_cause_reg <= BIS_LOCK_LOSSES;
            end else begin
              state_reg <= BIS_WAIT_PROVE;
            end
          end
        end
        BIS_LOCKOUT: begin
          // demand and power cannot end lockout; only the lockout timer or rst does
          if (timer_reg >= lim - CW'(1)) begin
            state_reg      <= BIS_IDLE;
            trials_reg     <= 2'h0;
            lock_cause_reg <= BIS_LOCK_NONE;
          end
        end
        default: state_reg <= BIS_IDLE;
      endcase
    end
  end

  // outputs, registered; qualifiers cut the valve without a hold state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gas_reg     <= 1'b0;
      spark_reg   <= 1'b0;
      sense_reg   <= 1'b0;
      lockout_reg <= 1'b0;
    end else begin
      gas_reg     <= live && link.demand &&
                     ((state_reg == BIS_TRIAL && !link.flame_sensed) ||
                      link.flame_sensed && (state_reg == BIS_RUN ||
                                            state_reg == BIS_TRIAL));
      spark_reg   <= live && link.demand && state_reg == BIS_TRIAL &&
                     !link.flame_sensed;
      sense_reg   <= live && (state_reg == BIS_TRIAL || state_reg == BIS_RUN);
      lockout_reg <= state_reg == BIS_LOCKOUT;
    end
  end
  assign link.gas_valve_first = gas_reg;
  assign link.spark           = spark_reg;
  assign link.flame_sense_en  = sense_reg;
  assign link.lockout         = lockout_reg;

  // flash indicator: slot tick, count of flashes, then dark pause
  logic [31:0] div_reg;
  logic        tick;
  logic [3:0]  slot_reg;
  logic [2:0]  code;
  logic        steady;
  logic        dark;
  assign tick = div_reg == 32'(FLASH_CYC - 64'h1);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  always_comb begin
    code   = 3'h0;
    steady = 1'b0;
    dark   = 1'b0;
    if (!VARIANT_B) begin
      if (hw_fault) begin
        code = 3'(`BIS_CODE_HW_FAULT);
      end else if (lock_cause_reg == BIS_LOCK_LOSSES) begin
        code = 3'(`BIS_CODE_LOCK_LOSS);
      end else if (lock_cause_reg == BIS_LOCK_TRIALS) begin
        code = 3'(`BIS_CODE_LOCK_TRIAL);
      end else begin
        steady = link.power_ok;
        dark   = !link.power_ok;
      end
    end else begin
      if (hw_fault) begin
        steady = 1'b1;
      end else if (state_reg == BIS_LOCKOUT) begin
        code = 3'(`BIS_CODE_B_LOCK);
      end else if (link.flame_sensed && !link.demand) begin
        code = 3'(`BIS_CODE_B_NO_DEM);
      end else begin
        dark = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot_reg <= 4'h0;
      led_reg  <= 1'b0;
    end else begin
      if (tick) begin
        if (slot_reg >= 4'({code, 1'b0}) + 4'(`BIS_PAUSE_SLOTS) - 4'h1) begin
          slot_reg <= 4'h0;
        end else begin
          slot_reg <= slot_reg + 4'h1;
        end
      end
      if (steady) begin
        led_reg <= 1'b1;
      end else if (dark || code == 3'h0) begin
        led_reg <= 1'b0;
      end else begin
        led_reg <= slot_reg < 4'({code, 1'b0}) && !slot_reg[0];
      end
    end
  end
endmodule

// ### hdl/bis_unit_controller.sv
`timescale 1ns/1ps
`include "bis_consts.svh"
module bis_unit_controller
  import bis_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // user side
  input  wire logic heat_call,
  input  wire logic supply_on,
  input  wire logic prove_switch,
  input  wire logic rollout_closed,
  input  wire logic flame_current,
  output logic      locked_reg,
  // link
  bis_link_if.unit link
);
  logic demand_reg;
  logic power_reg;
  logic prove_reg;
  logic roll_reg;
  logic flame_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      demand_reg <= 1'b0;
      power_reg  <= 1'b0;
      prove_reg  <= 1'b0;
      roll_reg   <= 1'b0;
      flame_reg  <= 1'b0;
      locked_reg <= 1'b0;
    end else begin
      demand_reg <= heat_call;
      power_reg  <= supply_on;
      prove_reg  <= prove_switch;
      roll_reg   <= rollout_closed;
      flame_reg  <= flame_current;
      locked_reg <= link.lockout;
    end
  end
  assign link.demand        = demand_reg;
  assign link.power_ok      = power_reg;
  assign link.prove_closed  = prove_reg;
  assign link.rollout_ok    = roll_reg;
  assign link.flame_sensed  = flame_reg;
  // inducer runs for the whole demand, retries included
  assign link.inducer_first = demand_reg;
endmodule

// ### include/bis_consts.svh
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH
// clock rate and documented times
`define BIS_CLK_HZ          20000000
`define BIS_PURGE_S         35
`define BIS_LOCKOUT_S       300
`define BIS_TRIAL_S         7
`define BIS_MAX_TRIALS      3
`define BIS_CODE_LOCK_TRIAL 3
`define BIS_CODE_LOCK_LOSS  4
`define BIS_CODE_HW_FAULT   5
`define BIS_CODE_B_NO_DEM   2
`define BIS_CODE_B_LOCK     3
`define BIS_FLASH_DIV       10000000
`define BIS_PAUSE_SLOTS     4
`endif

// ### include/bis_link_if.sv
`timescale 1ns/1ps
interface bis_link_if;
  logic demand;
  logic power_ok;
  logic prove_closed;
  logic rollout_ok;
  logic flame_sensed;
  logic gas_valve_first;
  logic spark;
  logic flame_sense_en;
  logic inducer_first;
  logic lockout;
  modport ignition (
    input  demand, power_ok, prove_closed, rollout_ok, flame_sensed,
    output gas_valve_first, spark, flame_sense_en, lockout
  );
  modport unit (
    input  lockout,
    output demand, power_ok, prove_closed, rollout_ok, flame_sensed, inducer_first
  );
endinterface

// ### include/bis_pkg.sv
package bis_pkg;
  typedef enum logic [2:0] {
    BIS_IDLE,
    BIS_PURGE,
    BIS_WAIT_PROVE,
    BIS_TRIAL,
    BIS_RUN,
    BIS_LOCKOUT
  } bis_state_t;
  typedef enum logic [1:0] {
    BIS_LOCK_NONE,
    BIS_LOCK_TRIALS,
    BIS_LOCK_LOSSES
  } bis_lock_t;
endpackage

// ### test/bis_link_props.sv
`timescale 1ns/1ps
module bis_link_props #(
  parameter int unsigned LOCKOUT_CYC = 100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link
  input wire logic demand,
  input wire logic power_ok,
  input wire logic rollout_ok,
  input wire logic prove_closed,
  input wire logic flame_sensed,
  input wire logic gas_valve_first,
  input wire logic spark,
  input wire logic flame_sense_en,
  input wire logic inducer_first,
  input wire logic lockout
);
  logic [15:0] lock_cnt_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lock_cnt_reg <= 16'h0000;
    else if (lockout) lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    else lock_cnt_reg <= 16'h0000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  spark_gas_a: assert property ($rose(spark) |-> gas_valve_first)
    else $error("spark without valve");
  purge_first_a: assert property ($rose(gas_valve_first) |-> $past(demand, 20))
    else $error("valve before purge");
  spark_stop_a: assert property (spark && flame_sensed |=> !spark)
    else $error("spark kept with flame");
  lock_quiet_a: assert property (lockout && $past(lockout) |-> !gas_valve_first && !spark)
    else $error("output during lockout");
  power_drop_a: assert property (!power_ok |=> !gas_valve_first)
    else $error("valve kept without power");
  rollout_drop_a: assert property (!rollout_ok |=> !gas_valve_first)
    else $error("valve kept on rollout");
  flame_hold_a: assert property (gas_valve_first && flame_sensed && power_ok && rollout_ok
    && demand && $past(flame_sensed) |=> gas_valve_first)
    else $error("valve dropped with flame");
  lock_len_a: assert property ($fell(lockout) |-> lock_cnt_reg >= LOCKOUT_CYC - 1
    && lock_cnt_reg <= LOCKOUT_CYC + 1)
    else $error("lockout length wrong");
  inducer_a: assert property (inducer_first == demand)
    else $error("inducer not following demand");
  sense_gas_a: assert property (gas_valve_first |-> flame_sense_en)
    else $error("valve without flame sensing");
  prove_spark_a: assert property ($rose(spark) |-> $past(prove_closed, 2))
    else $error("spark without prove");
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
`include "bis_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import bis_pkg::*;
  typedef struct packed {logic [1:0] fails; logic lock;} bis_row_t;
  bis_row_t   rows [3] = '{'{2'h3, 1'b1}, '{2'h2, 1'b0}, '{2'h0, 1'b0}};
  logic       clk_sys = 1'b0, rst = 1'b1, heat_call = 1'b0, supply_on = 1'b1;
  logic       prove_switch = 1'b1, rollout_closed = 1'b1, flame_current = 1'b0;
  logic       hw_fault = 1'b0;
  logic       locked_reg, led_reg, l, led_b, lb;
  int         n_fail = 0, n_checks = 0, cyc = 0, n, k, nb;
  // shortened times so that whole sequences fit in a short run
  localparam int unsigned PURGE_T = 20;
  localparam int unsigned LOCK_T  = 100;
  localparam int unsigned TRIAL_T = 30;
  localparam int unsigned FLASH_T = 4;
  bit         ok;
  always #25 clk_sys = ~clk_sys;
  bis_link_if bis_link_if_i ();
  bis_ignition_control_first #(.PURGE_CYC(PURGE_T), .LOCKOUT_CYC(LOCK_T), .TRIAL_CYC(TRIAL_T),
    .FLASH_CYC(FLASH_T)) bis_ignition_control_first_i (.clk_sys(clk_sys),
    .rst(rst), .link(bis_link_if_i), .hw_fault(hw_fault), .led_reg(led_reg));
  // second code set watches the same inputs through a link of its own
  bis_link_if bis_link_b_i ();
  assign bis_link_b_i.demand        = bis_link_if_i.demand;
  assign bis_link_b_i.power_ok      = bis_link_if_i.power_ok;
  assign bis_link_b_i.prove_closed  = bis_link_if_i.prove_closed;
  assign bis_link_b_i.rollout_ok    = bis_link_if_i.rollout_ok;
  assign bis_link_b_i.flame_sensed  = bis_link_if_i.flame_sensed;
  assign bis_link_b_i.inducer_first = bis_link_if_i.inducer_first;
  bis_ignition_control_first #(.PURGE_CYC(PURGE_T), .LOCKOUT_CYC(LOCK_T), .TRIAL_CYC(TRIAL_T),
    .FLASH_CYC(FLASH_T), .VARIANT_B(1'b1)) bis_ignition_control_first_b_i (.clk_sys(clk_sys),
    .rst(rst), .link(bis_link_b_i), .hw_fault(hw_fault), .led_reg(led_b));
  bis_unit_controller bis_unit_controller_i (.clk_sys(clk_sys), .rst(rst),
    .heat_call(heat_call), .supply_on(supply_on), .prove_switch(prove_switch),
    .rollout_closed(rollout_closed), .flame_current(flame_current),
    .locked_reg(locked_reg), .link(bis_link_if_i));
  bis_link_props #(.LOCKOUT_CYC(LOCK_T)) bis_link_props_i (.clk_sys(clk_sys), .rst(rst),
    .demand(bis_link_if_i.demand), .power_ok(bis_link_if_i.power_ok),
    .rollout_ok(bis_link_if_i.rollout_ok), .flame_sensed(bis_link_if_i.flame_sensed),
    .prove_closed(bis_link_if_i.prove_closed),
    .flame_sense_en(bis_link_if_i.flame_sense_en),
    .gas_valve_first(bis_link_if_i.gas_valve_first), .spark(bis_link_if_i.spark),
    .inducer_first(bis_link_if_i.inducer_first), .lockout(bis_link_if_i.lockout));
  task complete_run;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // the whole run is well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task cyc_n(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task wait_gas(input logic v, input int lim);
    ok = 1'b0;
    for (k = 0; k < lim && !ok; k++) begin
      @(negedge clk_sys);
      ok = (bis_link_if_i.gas_valve_first === v);
    end
  endtask
  // rising edges of both indicators over c cycles; one full flash period gives the code
  task count_rise(input int c);
    n = 0;
    nb = 0;
    for (k = 0; k < c; k++) begin
      l = led_reg;
      lb = led_b;
      cyc_n(1);
      if (l === 1'b0 && led_reg === 1'b1) n++;
      if (lb === 1'b0 && led_b === 1'b1) nb++;
    end
  endtask
  initial begin
    cyc_n(10);
    rst = 1'b0;
    cyc_n(5);
    `CHK("led", 1'b1, led_reg)
    foreach (rows[i]) begin
      heat_call = 1'b1;
      for (int t = 0; t < 3; t++) begin
        wait_gas(1'b1, 200);
        `CHK("gas on", 1'b1, ok)
        if (t >= rows[i].fails) begin
          flame_current = 1'b1;
          cyc_n(3);
          `CHK("spark", 1'b0, bis_link_if_i.spark)
          break;
        end
        wait_gas(1'b0, 60);
      end
      cyc_n(3);
      `CHK("lock", rows[i].lock, locked_reg)
      n = 0;
      while (bis_link_if_i.lockout === 1'b1) begin
        cyc_n(1);
        n++;
      end
      // lockout length checked on every row: more than 90 and fewer than 110 cycles if the row locks, else outside that range
      `CHK("lock time", rows[i].lock, (n > 90 && n < 110))
      heat_call = 1'b0;
      flame_current = 1'b0;
      cyc_n(5);
      $display("row %0d done", i);
    end
    prove_switch = 1'b0;
    heat_call = 1'b1;
    wait_gas(1'b1, 60);
    `CHK("prove held", 1'b0, ok)
    prove_switch = 1'b1;
    wait_gas(1'b1, 10);
    `CHK("prove go", 1'b1, ok)
    flame_current = 1'b1;
    cyc_n(3);
    flame_current = 1'b0;
    wait_gas(1'b0, 4);
    `CHK("loss off", 1'b1, ok)
    wait_gas(1'b1, 15);
    `CHK("relight", 1'b1, ok)
    flame_current = 1'b1;
    cyc_n(3);
    supply_on = 1'b0;
    wait_gas(1'b0, 3);
    `CHK("power off", 1'b1, ok)
    supply_on = 1'b1;
    wait_gas(1'b1, 200);
    `CHK("power back", 1'b1, ok)
    rollout_closed = 1'b0;
    wait_gas(1'b0, 3);
    `CHK("rollout", 1'b1, ok)
    rollout_closed = 1'b1;
    flame_current = 1'b0;
    // three flame losses in one demand end in lockout
    for (int j = 0; j < 3; j++) begin
      wait_gas(1'b1, 200);
      `CHK("sense", 1'b1, bis_link_if_i.flame_sense_en)
      flame_current = 1'b1;
      cyc_n(3);
      flame_current = 1'b0;
      wait_gas(1'b0, 4);
      `CHK("loss drop", 1'b1, ok)
    end
    for (k = 0; k < 1000 && locked_reg !== 1'b1; k++) cyc_n(1);
    `CHK("locked", 1'b1, locked_reg)
    count_rise((2 * `BIS_CODE_LOCK_LOSS + `BIS_PAUSE_SLOTS) * FLASH_T);
    `CHK("flash a", `BIS_CODE_LOCK_LOSS, n)
    count_rise((2 * `BIS_CODE_B_LOCK + `BIS_PAUSE_SLOTS) * FLASH_T);
    `CHK("flash b", `BIS_CODE_B_LOCK, nb)
    `CHK("lock held", 1'b1, bis_link_if_i.lockout)
    rst = 1'b1;
    cyc_n(2);
    `CHK("reset lock", 1'b0, bis_link_if_i.lockout)
    rst = 1'b0;
    hw_fault = 1'b1;
    cyc_n(3);
    `CHK("fault b", 1'b1, led_b)
    count_rise((2 * `BIS_CODE_HW_FAULT + `BIS_PAUSE_SLOTS) * FLASH_T);
    `CHK("fault a", `BIS_CODE_HW_FAULT, n)
    hw_fault = 1'b0;
    heat_call = 1'b0;
    flame_current = 1'b1;
    cyc_n(4);
    count_rise((2 * `BIS_CODE_B_NO_DEM + `BIS_PAUSE_SLOTS) * FLASH_T);
    `CHK("no demand b", `BIS_CODE_B_NO_DEM, nb)
    `CHK("healthy a", 1'b1, led_reg)
    flame_current = 1'b0;
    $display("hand tests done");
    complete_run();
  end
endmodule
